// ==== common/plafan_defines.svh ====
// Offsets, field positions, reset values and timing figures of the LED/autoneg bank
`ifndef PLAFAN_DEFINES_SVH
`define PLAFAN_DEFINES_SVH

`define PLAFAN_ADDR_W 5
`define PLAFAN_DATA_W 16
`define PLAFAN_OFS_LED_TIMING 5'h1a
`define PLAFAN_OFS_SPEEDUP 5'h1e

`define PLAFAN_LED_SKIP_BIT 2
`define PLAFAN_LED_RATE_HI 1
`define PLAFAN_LED_RATE_LO 0
`define PLAFAN_LED_SKIP_RST 1'h0
`define PLAFAN_LED_RATE_RST 2'h2

`define PLAFAN_PD_FAST_BIT 15
`define PLAFAN_AN_FAST_BIT 14
`define PLAFAN_AN_SEL_HI 13
`define PLAFAN_AN_SEL_LO 12
`define PLAFAN_PD_FAST_RST 1'h0
`define PLAFAN_AN_FAST_RST 1'h0
`define PLAFAN_AN_SEL_RST 2'h0

`define PLAFAN_MCLK_KHZ 100000
`define PLAFAN_BLINK_2HZ_MS 500
`define PLAFAN_BLINK_5HZ_MS 200
`define PLAFAN_BLINK_10HZ_MS 100
`define PLAFAN_BLINK_20HZ_MS 50
`define PLAFAN_STRETCH_MS 50

`define PLAFAN_BRK_00_MS 16'd80
`define PLAFAN_LFI_00_MS 16'd50
`define PLAFAN_WAIT_00_MS 16'd35
`define PLAFAN_BRK_01_MS 16'd120
`define PLAFAN_LFI_01_MS 16'd75
`define PLAFAN_WAIT_01_MS 16'd50
`define PLAFAN_BRK_10_MS 16'd240
`define PLAFAN_LFI_10_MS 16'd150
`define PLAFAN_WAIT_10_MS 16'd100
`define PLAFAN_BRK_NORM_MS 16'd1000
`define PLAFAN_LFI_NORM_MS 16'd750
`define PLAFAN_WAIT_NORM_MS 16'd500

`endif

// ==== common/plafan_pkg.sv ====
// Types shared by the LED/autoneg configuration bank
package plafan_pkg;
   typedef logic [1:0] plafan_rate_t;
   typedef logic [1:0] plafan_ansel_t;
   typedef struct packed {
      logic [15:0] brk_ms;
      logic [15:0] lfi_ms;
      logic [15:0] wait_ms;
   } plafan_timers_t;
endpackage : plafan_pkg

// ==== common/plafan_cfg_if.sv ====
// Configuration fields passed from the register bank to its sub-blocks
`timescale 1ns/1ps
interface plafan_cfg_if;
   import plafan_pkg::*;
   logic led_pulse_extend_skip;
   plafan_rate_t led_flash_period_sel;
   logic quick_negotiation_on;
   plafan_ansel_t quick_negotiation_timer_sel;
   modport src (
      output led_pulse_extend_skip,
      output led_flash_period_sel,
      output quick_negotiation_on,
      output quick_negotiation_timer_sel
   );
   modport snk (
      input led_pulse_extend_skip,
      input led_flash_period_sel,
      input quick_negotiation_on,
      input quick_negotiation_timer_sel
   );
endinterface : plafan_cfg_if

// ==== src/plafan_led.sv ====
// LED blink phase generator and activity pulse stretcher
`timescale 1ns/1ps
`include "plafan_defines.svh"
module plafan_led import plafan_pkg::*; #(
   parameter int unsigned P_CYC_PER_MS = `PLAFAN_MCLK_KHZ
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   plafan_cfg_if.snk cfg,
   input wire logic [3:0] i_led_act,
   output logic [3:0] o_led,
   output logic o_blink
);
   localparam logic [31:0] STRETCH_CYC = 32'(`PLAFAN_STRETCH_MS * P_CYC_PER_MS);

   function automatic logic [31:0] half_cycles(input plafan_rate_t sel);
      logic [31:0] ms;
      unique case (sel)
         2'h3: ms = 32'(`PLAFAN_BLINK_2HZ_MS);
         2'h2: ms = 32'(`PLAFAN_BLINK_5HZ_MS);
         2'h1: ms = 32'(`PLAFAN_BLINK_10HZ_MS);
         default: ms = 32'(`PLAFAN_BLINK_20HZ_MS);
      endcase
      // Period split in two phases, never below one cycle
      half_cycles = (ms * P_CYC_PER_MS) / 32'h2;
      if (half_cycles == 32'h0) begin
         half_cycles = 32'h1;
      end
   endfunction : half_cycles

   logic [31:0] bcnt_r, bcnt_nxt;
   logic blink_r, blink_nxt;
   plafan_rate_t rate_r, rate_nxt;
   logic [31:0] scnt_r [4];
   logic [31:0] scnt_nxt [4];
   logic [3:0] led_r, led_nxt;

   // R3: blink rate select
   always_comb begin
      rate_nxt = cfg.led_flash_period_sel;
      bcnt_nxt = bcnt_r + 32'h1;
      blink_nxt = blink_r;
      // Restart phase on a rate change so no truncated phase appears
      if (rate_r != cfg.led_flash_period_sel) begin
         bcnt_nxt = 32'h0;
      end else if (bcnt_r >= half_cycles(rate_r) - 32'h1) begin
         bcnt_nxt = 32'h0;
         blink_nxt = ~blink_r;
      end
   end

   // R2: stretch or bypass
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         scnt_nxt[i] = scnt_r[i];
         if (i_led_act[i]) begin
            scnt_nxt[i] = STRETCH_CYC;
         end else if (scnt_r[i] != 32'h0) begin
            scnt_nxt[i] = scnt_r[i] - 32'h1;
         end
         if (cfg.led_pulse_extend_skip) begin
            led_nxt[i] = i_led_act[i];
         end else begin
            led_nxt[i] = i_led_act[i] | (scnt_r[i] != 32'h0);
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         bcnt_r <= 32'h0;
         blink_r <= 1'h0;
         rate_r <= `PLAFAN_LED_RATE_RST;
         led_r <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            scnt_r[i] <= 32'h0;
         end
      end else begin
         bcnt_r <= bcnt_nxt;
         blink_r <= blink_nxt;
         rate_r <= rate_nxt;
         led_r <= led_nxt;
         for (int i = 0; i < 4; i++) begin
            scnt_r[i] <= scnt_nxt[i];
         end
      end
   end

   assign o_led = led_r;
   assign o_blink = blink_r;
endmodule : plafan_led

// ==== src/plafan_antmr.sv ====
// Auto-negotiation timer duration selection
`timescale 1ns/1ps
`include "plafan_defines.svh"
module plafan_antmr import plafan_pkg::*; (
   input wire logic i_mclk,
   input wire logic i_rst,
   plafan_cfg_if.snk cfg,
   output plafan_timers_t o_tmr
);
   plafan_timers_t tmr_r, tmr_nxt;

   // R5: fast or normal timers
   always_comb begin
      tmr_nxt = '{`PLAFAN_BRK_NORM_MS, `PLAFAN_LFI_NORM_MS, `PLAFAN_WAIT_NORM_MS};
      if (cfg.quick_negotiation_on) begin
         // R6: select table entry
         unique case (cfg.quick_negotiation_timer_sel)
            2'h0: tmr_nxt = '{`PLAFAN_BRK_00_MS, `PLAFAN_LFI_00_MS, `PLAFAN_WAIT_00_MS};
            2'h1: tmr_nxt = '{`PLAFAN_BRK_01_MS, `PLAFAN_LFI_01_MS, `PLAFAN_WAIT_01_MS};
            2'h2: tmr_nxt = '{`PLAFAN_BRK_10_MS, `PLAFAN_LFI_10_MS, `PLAFAN_WAIT_10_MS};
            // Undefined code keeps normal timing, the safe choice
            default: tmr_nxt = '{`PLAFAN_BRK_NORM_MS, `PLAFAN_LFI_NORM_MS,
               `PLAFAN_WAIT_NORM_MS};
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         tmr_r <= '{`PLAFAN_BRK_NORM_MS, `PLAFAN_LFI_NORM_MS, `PLAFAN_WAIT_NORM_MS};
      end else begin
         tmr_r <= tmr_nxt;
      end
   end

   assign o_tmr = tmr_r;
endmodule : plafan_antmr

// ==== src/plafan_top.sv ====
// LED timing and link speed-up configuration register bank
//
// Overview of operation
// R1: LED register bits 15:3 read zero
// R2: Bit 2 set bypasses LED pulse stretching
// R3: Bits 1:0 select blink rate, reset 10
// R4: Bit 15 enables fast parallel-detect link-up
// R5: Bit 14 enables fast auto-negotiation timers
// R6: Bits 13:12 pick fast timer durations
// R7: Partner should use same fast settings
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "plafan_defines.svh"
module plafan_top import plafan_pkg::*; #(
   parameter int unsigned P_CYC_PER_MS = `PLAFAN_MCLK_KHZ
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [`PLAFAN_ADDR_W-1:0] i_addr,
   input wire logic [`PLAFAN_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [`PLAFAN_DATA_W-1:0] o_rdata,
   input wire logic [3:0] i_led_act,
   output logic [3:0] o_led,
   output logic o_blink,
   output logic o_fast_pd_linkup,
   output logic o_fast_an,
   output logic [15:0] o_brk_link_ms,
   output logic [15:0] o_link_fail_inh_ms,
   output logic [15:0] o_an_wait_ms
);
   plafan_cfg_if cfg ();
   plafan_timers_t tmr;

   logic led_skip_r, led_skip_nxt;
   plafan_rate_t led_rate_r, led_rate_nxt;
   logic pd_fast_r, pd_fast_nxt;
   logic an_fast_r, an_fast_nxt;
   plafan_ansel_t an_sel_r, an_sel_nxt;
   logic [`PLAFAN_DATA_W-1:0] rdata_r, rdata_nxt;

   always_comb begin
      led_skip_nxt = led_skip_r;
      led_rate_nxt = led_rate_r;
      pd_fast_nxt = pd_fast_r;
      an_fast_nxt = an_fast_r;
      an_sel_nxt = an_sel_r;
      // Read data stands only in the cycle after the strobe
      rdata_nxt = '0;
      if (i_wr && i_addr == `PLAFAN_OFS_LED_TIMING) begin
         // R1: reserved writes dropped
         led_skip_nxt = i_wdata[`PLAFAN_LED_SKIP_BIT];
         led_rate_nxt = i_wdata[`PLAFAN_LED_RATE_HI:`PLAFAN_LED_RATE_LO];
      end
      if (i_wr && i_addr == `PLAFAN_OFS_SPEEDUP) begin
         // R4: fast link-up bit
         pd_fast_nxt = i_wdata[`PLAFAN_PD_FAST_BIT];
         an_fast_nxt = i_wdata[`PLAFAN_AN_FAST_BIT];
         an_sel_nxt = i_wdata[`PLAFAN_AN_SEL_HI:`PLAFAN_AN_SEL_LO];
      end
      if (i_rd) begin
         if (i_addr == `PLAFAN_OFS_LED_TIMING) begin
            // R1: reserved read zero
            rdata_nxt[`PLAFAN_LED_SKIP_BIT] = led_skip_r;
            rdata_nxt[`PLAFAN_LED_RATE_HI:`PLAFAN_LED_RATE_LO] = led_rate_r;
         end else if (i_addr == `PLAFAN_OFS_SPEEDUP) begin
            rdata_nxt[`PLAFAN_PD_FAST_BIT] = pd_fast_r;
            rdata_nxt[`PLAFAN_AN_FAST_BIT] = an_fast_r;
            rdata_nxt[`PLAFAN_AN_SEL_HI:`PLAFAN_AN_SEL_LO] = an_sel_r;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         led_skip_r <= `PLAFAN_LED_SKIP_RST;
         // R3: rate resets to 10
         led_rate_r <= `PLAFAN_LED_RATE_RST;
         pd_fast_r <= `PLAFAN_PD_FAST_RST;
         an_fast_r <= `PLAFAN_AN_FAST_RST;
         an_sel_r <= `PLAFAN_AN_SEL_RST;
         rdata_r <= '0;
      end else begin
         led_skip_r <= led_skip_nxt;
         led_rate_r <= led_rate_nxt;
         pd_fast_r <= pd_fast_nxt;
         an_fast_r <= an_fast_nxt;
         an_sel_r <= an_sel_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign cfg.led_pulse_extend_skip = led_skip_r;
   assign cfg.led_flash_period_sel = led_rate_r;
   assign cfg.quick_negotiation_on = an_fast_r;
   assign cfg.quick_negotiation_timer_sel = an_sel_r;

   plafan_led #(
      .P_CYC_PER_MS(P_CYC_PER_MS)
   ) u_led (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .cfg(cfg.snk),
      .i_led_act(i_led_act),
      .o_led(o_led),
      .o_blink(o_blink)
   );

   // R5: timer selection
   plafan_antmr u_antmr (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .cfg(cfg.snk),
      .o_tmr(tmr)
   );

   assign o_rdata = rdata_r;
   // R4: fast parallel-detect level
   assign o_fast_pd_linkup = pd_fast_r;
   // R7: same setting expected at partner
   assign o_fast_an = an_fast_r;
   assign o_brk_link_ms = tmr.brk_ms;
   assign o_link_fail_inh_ms = tmr.lfi_ms;
   assign o_an_wait_ms = tmr.wait_ms;
endmodule : plafan_top

// ==== tb/plafan_chk.sv ====
// Assertion checker for the LED/autoneg register bank
`timescale 1ns/1ps
module plafan_chk (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [4:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic [3:0] i_led_act,
   input wire logic [3:0] o_led,
   input wire logic o_fast_pd_linkup,
   input wire logic o_fast_an,
   input wire logic [15:0] o_brk_link_ms,
   input wire logic [15:0] o_link_fail_inh_ms,
   input wire logic [15:0] o_an_wait_ms
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   sequence s_cfg_wr;
      i_wr && i_addr == 5'h1e;
   endsequence
   property p_led_rsvd;
      i_rd && i_addr == 5'h1a |=> o_rdata[15:3] == 13'h0;
   endproperty
   a_led_rsvd: assert property (p_led_rsvd) else $error("led reserved bits set");
   property p_led_on;
      $rose(i_led_act[0]) |=> o_led[0];
   endproperty
   a_led_on: assert property (p_led_on) else $error("led not lit");
   property p_pd;
      s_cfg_wr |=> o_fast_pd_linkup == $past(i_wdata[15]);
   endproperty
   a_pd: assert property (p_pd) else $error("fast link-up wrong");
   property p_an;
      s_cfg_wr |=> o_fast_an == $past(i_wdata[14]);
   endproperty
   a_an: assert property (p_an) else $error("fast negotiation wrong");
   property p_sel10;
      s_cfg_wr ##0 i_wdata[14:12] == 3'h6 |=> ##1
         o_brk_link_ms == 16'hf0 && o_link_fail_inh_ms == 16'h96 && o_an_wait_ms == 16'h64;
   endproperty
   a_sel10: assert property (p_sel10) else $error("timers for code 10 wrong");
   property p_norm;
      s_cfg_wr ##0 !i_wdata[14] |=> ##1 o_link_fail_inh_ms == 16'h2ee;
   endproperty
   a_norm: assert property (p_norm) else $error("normal timers wrong");
endmodule : plafan_chk
bind plafan_top plafan_chk chk_u (.*);

// ==== tb/testbench.sv ====
// Self-checking bench for the LED/autoneg register bank
`timescale 1ns/1ps
module testbench;
   logic i_mclk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
   logic [4:0] i_addr = 5'h0;
   logic [15:0] i_wdata = 16'h0;
   logic [3:0] i_led_act = 4'h0;
   logic [15:0] o_rdata, o_brk_link_ms, o_link_fail_inh_ms, o_an_wait_ms;
   logic [3:0] o_led;
   logic o_blink, o_fast_pd_linkup, o_fast_an;
   int mismatches = 0;
   int num_checks = 0;
   always #5 i_mclk = ~i_mclk;
   // Short scale keeps blink and stretch counts small
   plafan_top #(.P_CYC_PER_MS(10)) dut_u (.*);
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(logic [4:0] a, logic [15:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [4:0] a, logic [15:0] exp);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 chk("rdata", exp, o_rdata);
      // Read data stands one cycle only
      @(posedge i_mclk);
      #1 chk("rdata idle", 16'h0, o_rdata);
   endtask : rd
   // Timers settle two edges after the write edge
   task automatic tmr(logic [15:0] b, logic [15:0] l, logic [15:0] w);
      repeat (2) @(posedge i_mclk);
      #1 chk("brk", b, o_brk_link_ms);
      chk("lfi", l, o_link_fail_inh_ms);
      chk("wait", w, o_an_wait_ms);
   endtask : tmr
   task automatic wait_tog(output int n);
      logic b;
      #1 b = o_blink;
      n = 0;
      while (o_blink === b) begin
         @(posedge i_mclk);
         #1 n++;
         if (n > 3000) begin
            mismatches++;
            final_report();
         end
      end
   endtask : wait_tog
   task automatic t_reset;
      rd(5'h1a, 16'h0002);
      rd(5'h1e, 16'h0000);
      tmr(16'h3e8, 16'h2ee, 16'h1f4);
      $display("reset test done");
   endtask : t_reset
   task automatic t_regs;
      wr(5'h1a, 16'hffff);
      rd(5'h1a, 16'h0007);
      wr(5'h1b, 16'hffff);
      rd(5'h1b, 16'h0000);
      $display("register test done");
   endtask : t_regs
   task automatic t_cfg;
      logic [15:0] bt [4] = '{16'h50, 16'h78, 16'hf0, 16'h3e8};
      logic [15:0] lt [4] = '{16'h32, 16'h4b, 16'h96, 16'h2ee};
      logic [15:0] wt [4] = '{16'h23, 16'h32, 16'h64, 16'h1f4};
      for (int s = 0; s < 4; s++) begin
         wr(5'h1e, {2'h3, s[1:0], 12'hfff});
         tmr(bt[s], lt[s], wt[s]);
         chk("pd", 16'h1, o_fast_pd_linkup);
         chk("an", 16'h1, o_fast_an);
         rd(5'h1e, {2'h3, s[1:0], 12'h0});
      end
      wr(5'h1e, 16'h1000);
      tmr(16'h3e8, 16'h2ee, 16'h1f4);
      chk("pd", 16'h0, o_fast_pd_linkup);
      chk("an", 16'h0, o_fast_an);
      $display("config test done");
   endtask : t_cfg
   task automatic t_blink;
      int per [4] = '{250, 500, 1000, 2500};
      int n;
      for (int r = 0; r < 4; r++) begin
         wr(5'h1a, {14'h0, r[1:0]});
         wait_tog(n);
         wait_tog(n);
         chk("blink", 16'(per[r]), 16'(n));
      end
      $display("blink test done");
   endtask : t_blink
   task automatic t_led(logic [15:0] skip);
      wr(5'h1a, skip | 16'h0002);
      @(posedge i_mclk);
      i_led_act <= 4'h5;
      @(posedge i_mclk);
      i_led_act <= 4'h0;
      #1 chk("led", 16'h5, o_led);
      @(posedge i_mclk);
      #1 chk("led", skip ? 16'h0 : 16'h5, o_led);
      // Stretch of 50 ms is 500 cycles here
      repeat (490) @(posedge i_mclk);
      #1 chk("led", skip ? 16'h0 : 16'h5, o_led);
      repeat (30) @(posedge i_mclk);
      #1 chk("led", 16'h0, o_led);
      $display("led test done");
   endtask : t_led
   // Reset in mid-run must restore every field
   task automatic t_rerst;
      wr(5'h1a, 16'h0005);
      wr(5'h1e, 16'he000);
      @(posedge i_mclk);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_mclk);
      i_rst <= 1'b0;
      #1 chk("led", 16'h0, o_led);
      chk("blink", 16'h0, o_blink);
      chk("pd", 16'h0, o_fast_pd_linkup);
      t_reset();
      $display("mid-run reset test done");
   endtask : t_rerst
   initial begin
      repeat (12) @(posedge i_mclk);
      i_rst <= 1'b0;
      t_reset();
      t_regs();
      t_cfg();
      t_blink();
      t_led(16'h4);
      t_led(16'h0);
      t_rerst();
      final_report();
   end
endmodule : testbench
